// >>> common/eia_regs.svh
// Register offsets, field positions and counts for the EEPROM indirect access block
// How it works
// R1: Bit 0 of the ready-status register reads 1 when the EEPROM can take an access, else 0.
// R2: Bits 7:0 of the single-address register give the EEPROM location of every single access.
// R3: A single address of 0x90 reaches the EEPROM word behind the first configuration word.
// R4: A single write stores the 16-bit single write-data register at the single address.
// R5: Shadow select at 1 runs the device from the shadow copies; at 0 they are not used.
// R6: With shadow select at 1, host reads of configuration words return the shadow copies.
// R7: Writing shadow reload as 1 copies the EEPROM into the shadows; 0 is normal operation.
// R8: Direction bit 2 at 0 selects an EEPROM read and at 1 an EEPROM write.
// R9: Access mode bits 1:0 decode 00 as disabled, 01 as single access and 10 as mass access.
// R10: The host never writes access mode 11.
// R11: After a single read the read-data register holds the word read from the EEPROM.
// R12: The host leaves reserved bits alone and the device reads them as zero.
// R13: The host writes the unlock key before touching configuration locations 0x90 to 0x96.
// R14: Write-only motor halt bit 15 stops motor control without sleep; 0 keeps it running.
// R15: The host polls the ready flag for 1 before each new read, write or reload.
// R16: The ready flag drops while an EEPROM operation runs and returns when it ends.
`ifndef EIA_REGS_SVH
`define EIA_REGS_SVH
`define EIA_ADDR_KEY     8'h31
`define EIA_ADDR_READY   8'h32
`define EIA_ADDR_SADDR   8'h33
`define EIA_ADDR_WWORD   8'h34
`define EIA_ADDR_CTRL    8'h35
`define EIA_ADDR_RWORD   8'h36
`define EIA_ADDR_HALT    8'h60
`define EIA_CFG_BASE     8'h90
`define EIA_CFG_LAST     8'h96
`define EIA_CFG_WORDS    7
`define EIA_CFG_LAST_IDX 3'h6
`define EIA_BIT_SHADOW   12
`define EIA_BIT_RELOAD   8
`define EIA_BIT_DIR      2
`define EIA_BIT_HALT     15
`define EIA_RST_WORD     16'h0000
`define EIA_NVM_CYCLES   16
`define EIA_NVM_DEPTH    256
`endif

// >>> common/eia_pkg.sv
// Types shared by the EEPROM indirect access block
`default_nettype none
package eia_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SINGLE = 2'b01,
        ST_BULK   = 2'b11
    } eia_state_type;
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_MASS   = 2'b10,
        MODE_BAD    = 2'b11
    } eia_mode_type;
endpackage
`default_nettype wire

// >>> design/eia_nvm.sv
// Nonvolatile word store with a fixed operation time
`timescale 1ns/1ps
`default_nettype none
module eia_nvm #(
    parameter int WIDTH     = 16,
    parameter int DEPTH     = 256,
    parameter int OP_CYCLES = 16
) (
    // Clock and reset
    input  wire logic             CORE_CLK,
    input  wire logic             RST_B,
    // Operation port
    input  wire logic             start,
    input  wire logic             write,
    input  wire logic [7:0]       addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic                  done,
    output logic [WIDTH-1:0]      rdata,
    // Direct look-up ports
    input  wire logic [7:0]       peek_a_addr,
    output logic [WIDTH-1:0]      peek_a_data,
    input  wire logic [7:0]       peek_b_addr,
    output logic [WIDTH-1:0]      peek_b_data
);
    localparam int CW = $clog2(OP_CYCLES + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0]    count;
    logic             busy;
    logic             hold_write;
    logic [7:0]       hold_addr;
    logic [WIDTH-1:0] hold_wdata;
    wire              finish = busy && (count == '0);

    assign peek_a_data = mem[peek_a_addr];
    assign peek_b_data = mem[peek_b_addr];

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            busy       <= 1'b0;
            count      <= '0;
            done       <= 1'b0;
            rdata      <= '0;
            hold_write <= 1'b0;
            hold_addr  <= 8'h00;
            hold_wdata <= '0;
        end
        else
        begin
            done <= finish;
            if (start && !busy)
            begin
                busy       <= 1'b1;
                count      <= CW'(OP_CYCLES - 1);
                hold_write <= write;
                hold_addr  <= addr;
                hold_wdata <= wdata;
            end
            else if (finish)
            begin
                busy <= 1'b0;
                if (!hold_write)
                    rdata <= mem[hold_addr];
            end
            else if (busy)
                count <= count - 1'b1;
        end
    end

    // Array has no reset: contents survive like real cells
    always_ff @(posedge CORE_CLK)
    begin
        if (finish && hold_write)
            mem[hold_addr] <= hold_wdata;
    end
endmodule
`default_nettype wire

// >>> design/eia_top.sv
// EEPROM indirect access registers, shadow copies and operation sequencer
`timescale 1ns/1ps
`default_nettype none
`include "eia_regs.svh"
module eia_top
    import eia_pkg::*;
#(
    parameter int NVM_CYCLES = `EIA_NVM_CYCLES
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic        REG_WR_EN,
    input  wire logic        REG_RD_EN,
    input  wire logic [15:0] REG_WDATA,
    output logic [15:0]      REG_RDATA,
    // Configuration feed to the motor logic
    input  wire logic [2:0]  ACTIVE_CFG_INDEX,
    output logic [15:0]      ACTIVE_CFG_WORD,
    output logic             SHADOW_IN_USE,
    output logic             MOTOR_HALT
);
    eia_state_type state;
    eia_mode_type  nvm_access_mode;
    logic          nvm_ready_flag;
    logic [7:0]    single_access_location;
    logic [15:0]   single_write_word;
    logic [15:0]   single_read_word;
    logic          access_direction;
    logic          shadow_copy_select;
    logic          shadow_reload;
    logic [15:0]   shadow [`EIA_CFG_WORDS];
    logic          issue;
    logic          op_write;
    logic [7:0]    op_addr;
    logic [15:0]   op_wdata;
    logic [2:0]    bulk_idx;
    logic          nvm_done;
    logic [15:0]   nvm_rdata;
    logic [15:0]   peek_a_data;
    logic [15:0]   peek_b_data;

    // Decode
    wire          ctrl_wr      = REG_WR_EN && (REG_ADDR == `EIA_ADDR_CTRL);
    wire          cfg_hit      = (REG_ADDR >= `EIA_CFG_BASE) && (REG_ADDR <= `EIA_CFG_LAST);
    wire [2:0]    cfg_idx      = 3'(REG_ADDR - `EIA_CFG_BASE);
    wire          can_start    = ctrl_wr && (state == ST_IDLE);
    wire          reload_bit   = REG_WDATA[`EIA_BIT_RELOAD];
    wire [1:0]    mode_field   = REG_WDATA[1:0];
    wire          dir_bit      = REG_WDATA[`EIA_BIT_DIR];
    // Mode 11 starts nothing unless the reload bit is set, and is treated as disabled
    wire          start_reload = can_start && (reload_bit ||
                                 (mode_field == MODE_MASS && !dir_bit)); // R7 R9
    wire          start_store  = can_start && !reload_bit && mode_field == MODE_MASS
                                 && dir_bit; // R9
    wire          start_single = can_start && !reload_bit && mode_field == MODE_SINGLE; // R9
    wire          any_start    = start_reload || start_store || start_single;
    wire [2:0]    next_idx     = 3'(bulk_idx + 3'h1);
    wire [7:0]    active_addr  = 8'(`EIA_CFG_BASE + {5'h00, ACTIVE_CFG_INDEX});
    wire          active_ok    = ACTIVE_CFG_INDEX <= `EIA_CFG_LAST_IDX;
    wire [15:0]   cfg_rd_word  = shadow_copy_select ? shadow[cfg_idx] : peek_a_data; // R6
    wire [15:0]   ctrl_word    = {3'h0, shadow_copy_select, 3'h0, shadow_reload,
                                  5'h00, access_direction, nvm_access_mode};
    // Reserved bits and the write-only halt bit read as zero
    wire [15:0]   rd_mux =
        (REG_ADDR == `EIA_ADDR_READY) ? {15'h0000, nvm_ready_flag} : // R1 R12
        (REG_ADDR == `EIA_ADDR_SADDR) ? {8'h00, single_access_location} :
        (REG_ADDR == `EIA_ADDR_WWORD) ? single_write_word :
        (REG_ADDR == `EIA_ADDR_CTRL)  ? ctrl_word :
        (REG_ADDR == `EIA_ADDR_RWORD) ? single_read_word :
        cfg_hit                       ? cfg_rd_word : `EIA_RST_WORD;

    eia_nvm #(
        .WIDTH     (16),
        .DEPTH     (`EIA_NVM_DEPTH),
        .OP_CYCLES (NVM_CYCLES)
    ) u_nvm (
        .CORE_CLK    (CORE_CLK),
        .RST_B       (RST_B),
        .start       (issue),
        .write       (op_write),
        .addr        (op_addr),
        .wdata       (op_wdata),
        .done        (nvm_done),
        .rdata       (nvm_rdata),
        .peek_a_addr (REG_ADDR),
        .peek_a_data (peek_a_data),
        .peek_b_addr (active_addr),
        .peek_b_data (peek_b_data)
    );

    // Host-visible registers
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            single_access_location <= 8'h00;
            single_write_word      <= `EIA_RST_WORD;
            nvm_access_mode        <= MODE_OFF;
            access_direction       <= 1'b0;
            shadow_copy_select     <= 1'b0;
            MOTOR_HALT             <= 1'b0;
            REG_RDATA              <= `EIA_RST_WORD;
            nvm_ready_flag         <= 1'b0;
        end
        else
        begin
            if (REG_WR_EN && REG_ADDR == `EIA_ADDR_SADDR)
                single_access_location <= REG_WDATA[7:0]; // R2
            if (REG_WR_EN && REG_ADDR == `EIA_ADDR_WWORD)
                single_write_word <= REG_WDATA; // R4
            if (ctrl_wr)
            begin
                nvm_access_mode    <= eia_mode_type'(mode_field); // R9
                access_direction   <= dir_bit; // R8
                shadow_copy_select <= REG_WDATA[`EIA_BIT_SHADOW]; // R5
            end
            if (REG_WR_EN && REG_ADDR == `EIA_ADDR_HALT)
                MOTOR_HALT <= REG_WDATA[`EIA_BIT_HALT]; // R14
            if (REG_RD_EN)
                REG_RDATA <= rd_mux;
            nvm_ready_flag <= (state == ST_IDLE) && !any_start; // R1 R16
        end
    end

    // Sequencer: one single access, or a walk over all configuration words
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            state            <= ST_IDLE;
            issue            <= 1'b0;
            op_write         <= 1'b0;
            op_addr          <= 8'h00;
            op_wdata         <= `EIA_RST_WORD;
            bulk_idx         <= 3'h0;
            shadow_reload    <= 1'b0;
            single_read_word <= `EIA_RST_WORD;
        end
        else
        begin
            issue <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    if (start_single)
                    begin
                        state    <= ST_SINGLE;
                        issue    <= 1'b1;
                        op_addr  <= single_access_location; // R2 R3
                        op_wdata <= single_write_word; // R4
                        op_write <= dir_bit; // R8
                    end
                    else if (start_reload || start_store)
                    begin
                        state         <= ST_BULK;
                        issue         <= 1'b1;
                        bulk_idx      <= 3'h0;
                        op_addr       <= `EIA_CFG_BASE; // R3
                        op_wdata      <= shadow[0];
                        op_write      <= start_store;
                        shadow_reload <= start_reload; // R7
                    end
                end
                ST_SINGLE:
                begin
                    if (nvm_done)
                    begin
                        state <= ST_IDLE;
                        if (!op_write)
                            single_read_word <= nvm_rdata; // R11
                    end
                end
                ST_BULK:
                begin
                    if (nvm_done && bulk_idx == `EIA_CFG_LAST_IDX)
                    begin
                        state         <= ST_IDLE;
                        shadow_reload <= 1'b0; // R7
                    end
                    else if (nvm_done)
                    begin
                        bulk_idx <= next_idx;
                        op_addr  <= 8'(op_addr + 8'h01);
                        op_wdata <= shadow[next_idx];
                        issue    <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Shadow copies; a reload landing beats a host write in the same cycle
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < `EIA_CFG_WORDS; i++)
                shadow[i] <= `EIA_RST_WORD;
            ACTIVE_CFG_WORD <= `EIA_RST_WORD;
        end
        else
        begin
            if (state == ST_BULK && nvm_done && !op_write)
                shadow[bulk_idx] <= nvm_rdata; // R7
            else if (REG_WR_EN && cfg_hit)
                shadow[cfg_idx] <= REG_WDATA;
            if (!active_ok)
                ACTIVE_CFG_WORD <= `EIA_RST_WORD;
            else
                ACTIVE_CFG_WORD <= shadow_copy_select ? shadow[ACTIVE_CFG_INDEX[2:0]]
                                                      : peek_b_data; // R5
        end
    end

    assign SHADOW_IN_USE = shadow_copy_select; // R5

    property p_ready_drop;
        @(posedge CORE_CLK) disable iff (!RST_B) any_start |=> !nvm_ready_flag [*2];
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high"); // R16
    property p_ready_back;
        @(posedge CORE_CLK) disable iff (!RST_B)
            state == ST_SINGLE && nvm_done |=> ##1 nvm_ready_flag;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored"); // R1
    property p_single_addr;
        @(posedge CORE_CLK) disable iff (!RST_B)
            issue && state == ST_SINGLE |-> op_addr == single_access_location;
    endproperty
    a_single_addr: assert property (p_single_addr) else $error("wrong location"); // R2
    property p_cfg_base;
        @(posedge CORE_CLK) disable iff (!RST_B)
            issue && state == ST_BULK && bulk_idx == 3'h0 |-> op_addr == `EIA_CFG_BASE;
    endproperty
    a_cfg_base: assert property (p_cfg_base) else $error("walk not at 0x90"); // R3
    property p_wdata;
        @(posedge CORE_CLK) disable iff (!RST_B)
            issue && state == ST_SINGLE && op_write |-> op_wdata == single_write_word;
    endproperty
    a_wdata: assert property (p_wdata) else $error("wrong write word"); // R4
    property p_host_shadow;
        @(posedge CORE_CLK) disable iff (!RST_B)
            REG_RD_EN && cfg_hit && shadow_copy_select |=> REG_RDATA == $past(shadow[cfg_idx]);
    endproperty
    a_host_shadow: assert property (p_host_shadow) else $error("shadow not read"); // R6
    property p_reload_ends;
        @(posedge CORE_CLK) disable iff (!RST_B)
            start_reload |=> shadow_reload ##[1:400] !shadow_reload;
    endproperty
    a_reload_ends: assert property (p_reload_ends) else $error("reload stuck"); // R7
    property p_dir;
        @(posedge CORE_CLK) disable iff (!RST_B) start_single |=> op_write == access_direction;
    endproperty
    a_dir: assert property (p_dir) else $error("direction mismatch"); // R8
    property p_mode_off;
        @(posedge CORE_CLK) disable iff (!RST_B)
            ctrl_wr && !reload_bit && mode_field[1] == mode_field[0] |=> $stable(state);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("start in off mode"); // R9
    property p_rdata;
        @(posedge CORE_CLK) disable iff (!RST_B)
            state == ST_SINGLE && nvm_done && !op_write |=> single_read_word == $past(nvm_rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read word not held"); // R11
    property p_reserved;
        @(posedge CORE_CLK) disable iff (!RST_B)
            REG_RD_EN && REG_ADDR == `EIA_ADDR_READY |=> REG_RDATA[15:1] == 15'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set"); // R12
    property p_halt;
        @(posedge CORE_CLK) disable iff (!RST_B)
            REG_WR_EN && REG_ADDR == `EIA_ADDR_HALT |=> MOTOR_HALT == $past(REG_WDATA[15]);
    endproperty
    a_halt: assert property (p_halt) else $error("halt not taken"); // R14
endmodule
`default_nettype wire

// >>> tb/eia_host_model.sv
// Register-port host model: bus cycles on the falling edge, ready polling
`timescale 1ns/1ps
`default_nettype none
`include "eia_regs.svh"
module eia_host_model #(
    parameter logic [15:0] UNLOCK_KEY = 16'hc0de
) (
    // Clock
    input  wire logic        CORE_CLK,
    // Register port
    output logic [7:0]       REG_ADDR,
    output logic             REG_WR_EN,
    output logic             REG_RD_EN,
    output logic [15:0]      REG_WDATA,
    input  wire logic [15:0] REG_RDATA
);
    initial
    begin
        REG_ADDR  = 8'h00;
        REG_WR_EN = 1'b0;
        REG_RD_EN = 1'b0;
        REG_WDATA = 16'h0000;
    end

    // Released lines show the inverse, so a stale value cannot pass
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    begin
        @(negedge CORE_CLK);
        REG_ADDR  = addr;
        REG_WDATA = data;
        REG_WR_EN = 1'b1;
        @(negedge CORE_CLK);
        REG_WR_EN = 1'b0;
        REG_ADDR  = ~addr;
        REG_WDATA = ~data;
    end
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    begin
        @(negedge CORE_CLK);
        REG_ADDR  = addr;
        REG_RD_EN = 1'b1;
        @(negedge CORE_CLK);
        REG_RD_EN = 1'b0;
        REG_ADDR  = ~addr;
        data      = REG_RDATA;
    end
    endtask

    // Bounded poll; ok stays low if the flag never returns
    task automatic wait_ready(output logic ok);
        logic [15:0] rd;
    begin
        ok = 1'b0;
        for (int i = 0; i < 200 && ok !== 1'b1; i++)
        begin
            read_reg(`EIA_ADDR_READY, rd);
            ok = rd[0];
        end
    end
    endtask

    // Key ahead of configuration accesses
    task automatic unlock();
    begin
        write_reg(`EIA_ADDR_KEY, UNLOCK_KEY);
    end
    endtask

    // Control write after the ready poll, sent even if the poll timed out; reserved bits clear, mode 11 never sent
    task automatic start_op(input logic [15:0] ctrl, output logic ok);
    begin
        wait_ready(ok);
        if (ctrl[1:0] != 2'b11)
        begin
            write_reg(`EIA_ADDR_CTRL, ctrl & 16'h1107);
        end
    end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_eia_top.sv
// Self-checking bench for the EEPROM indirect access block
`timescale 1ns/1ps
`default_nettype none
`include "eia_regs.svh"
`define CHK(NM, EXP, GOT) \
    begin \
        n_compared++; \
        if ((GOT) !== (EXP)) \
        begin \
            mismatches++; \
            $display("BAD %s expected %h seen %h", NM, EXP, GOT); \
        end \
    end
module tb_eia_top;
    logic        CORE_CLK;
    logic        RST_B;
    logic [7:0]  REG_ADDR;
    logic        REG_WR_EN;
    logic        REG_RD_EN;
    logic [15:0] REG_WDATA;
    logic [15:0] REG_RDATA;
    logic [2:0]  ACTIVE_CFG_INDEX;
    logic [15:0] ACTIVE_CFG_WORD;
    logic        SHADOW_IN_USE;
    logic        MOTOR_HALT;
    int          mismatches;
    int          n_compared;
    int          cycles;
    logic        ok;

    eia_top #(.NVM_CYCLES(2)) DUT (
        .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WR_EN(REG_WR_EN), .REG_RD_EN(REG_RD_EN), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .ACTIVE_CFG_INDEX(ACTIVE_CFG_INDEX),
        .ACTIVE_CFG_WORD(ACTIVE_CFG_WORD), .SHADOW_IN_USE(SHADOW_IN_USE),
        .MOTOR_HALT(MOTOR_HALT)
    );
    eia_host_model host (
        .CORE_CLK(CORE_CLK), .REG_ADDR(REG_ADDR), .REG_WR_EN(REG_WR_EN),
        .REG_RD_EN(REG_RD_EN), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA)
    );

    initial
    begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [15:0] cfg_pat(input int i);
        return 16'h3c00 + 16'(i) * 16'h0111;
    endfunction

    task automatic expect_reg(input logic [7:0] a, input logic [15:0] e, input string nm);
        logic [15:0] rd;
    begin
        host.read_reg(a, rd);
        `CHK(nm, e, rd)
    end
    endtask

    task automatic print_verdict();
    begin
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        RST_B = 1'b0;
        ACTIVE_CFG_INDEX = 3'h1;
        mismatches = 0;
        n_compared = 0;
        cycles = 0;
        repeat (16) @(negedge CORE_CLK);
        `CHK("halt in reset", 1'b0, MOTOR_HALT)
        `CHK("shadow in reset", 1'b0, SHADOW_IN_USE)
        RST_B = 1'b1;
        expect_reg(`EIA_ADDR_READY, 16'h0001, "ready after reset");
        for (int a = 8'h33; a <= 8'h36; a++)
            expect_reg(8'(a), 16'h0000, "reset value");
        host.write_reg(8'h37, 16'hffff);
        expect_reg(8'h37, 16'h0000, "unmapped");
        host.unlock();
        // Mass store of all shadow words, then read the EEPROM back
        for (int i = 0; i < 7; i++)
            host.write_reg(8'(8'h90 + i), cfg_pat(i));
        host.start_op(16'h0006, ok);
        expect_reg(`EIA_ADDR_READY, 16'h0000, "busy mass");
        host.start_op(16'h0000, ok);
        `CHK("ready poll", 1'b1, ok)
        for (int i = 0; i < 7; i++)
            expect_reg(8'(8'h90 + i), cfg_pat(i), "eeprom word");
        // Single write to 0x91, single reads of 0x91 and 0x90
        host.write_reg(`EIA_ADDR_SADDR, 16'h0091);
        expect_reg(`EIA_ADDR_SADDR, 16'h0091, "address reg");
        host.write_reg(`EIA_ADDR_WWORD, 16'ha5c3);
        expect_reg(`EIA_ADDR_WWORD, 16'ha5c3, "write word");
        host.start_op(16'h0005, ok);
        expect_reg(`EIA_ADDR_READY, 16'h0000, "busy single");
        host.start_op(16'h0001, ok);
        host.wait_ready(ok);
        expect_reg(`EIA_ADDR_RWORD, 16'ha5c3, "read word 91");
        expect_reg(8'h91, 16'ha5c3, "eeprom 91");
        expect_reg(8'h92, cfg_pat(2), "eeprom 92 kept");
        host.write_reg(`EIA_ADDR_SADDR, 16'h0090);
        host.start_op(16'h0001, ok);
        host.wait_ready(ok);
        expect_reg(`EIA_ADDR_RWORD, cfg_pat(0), "read word 90");
        // Shadow select on: host view and motor feed follow the shadows
        host.start_op(16'h1004, ok);
        `CHK("shadow port", 1'b1, SHADOW_IN_USE)
        expect_reg(`EIA_ADDR_READY, 16'h0001, "mode off no op");
        host.write_reg(8'h91, 16'h7e81);
        expect_reg(8'h91, 16'h7e81, "shadow read");
        repeat (2) @(negedge CORE_CLK);
        `CHK("feed shadow", 16'h7e81, ACTIVE_CFG_WORD)
        host.start_op(16'h0000, ok);
        repeat (2) @(negedge CORE_CLK);
        `CHK("feed eeprom", 16'ha5c3, ACTIVE_CFG_WORD)
        ACTIVE_CFG_INDEX = 3'h7;
        repeat (2) @(negedge CORE_CLK);
        `CHK("feed out of range", 16'h0000, ACTIVE_CFG_WORD)
        ACTIVE_CFG_INDEX = 3'h1;
        `CHK("shadow port off", 1'b0, SHADOW_IN_USE)
        // Reload brings the shadow back to the EEPROM word
        host.start_op(16'h1100, ok);
        expect_reg(`EIA_ADDR_CTRL, 16'h1100, "reload pending");
        host.wait_ready(ok);
        expect_reg(`EIA_ADDR_CTRL, 16'h1000, "reload done");
        expect_reg(8'h91, 16'ha5c3, "shadow synced");
        // Mass mode in the read direction refreshes the shadows as well
        host.write_reg(8'h92, 16'h0f0f);
        expect_reg(8'h92, 16'h0f0f, "shadow dirty");
        host.start_op(16'h1002, ok);
        host.wait_ready(ok);
        expect_reg(`EIA_ADDR_CTRL, 16'h1002, "mass read done");
        expect_reg(8'h92, cfg_pat(2), "mass read shadow");
        // Write-only motor halt
        host.write_reg(`EIA_ADDR_HALT, 16'h8000);
        `CHK("halt on", 1'b1, MOTOR_HALT)
        expect_reg(`EIA_ADDR_HALT, 16'h0000, "halt unreadable");
        host.write_reg(`EIA_ADDR_HALT, 16'h0000);
        `CHK("halt off", 1'b0, MOTOR_HALT)
        // Second reset in mid-run
        RST_B = 1'b0;
        repeat (16) @(negedge CORE_CLK);
        RST_B = 1'b1;
        `CHK("shadow after reset", 1'b0, SHADOW_IN_USE)
        expect_reg(`EIA_ADDR_READY, 16'h0001, "ready again");
        print_verdict();
    end
endmodule
`default_nettype wire
